// [core_exec.sv]
// Purpose: two-cycle execute core for add through load instructions
// Assumes: program memory answers pc_out combinationally
// Notes:   opcodes outside this set execute as no-ops
// Summary of operation
// - add writes eight-bit sum, updates both flags
// - add with carry includes carry flag input
// - and stores result, carry forced to zero
// - call pushes pc, loads target address
// - conditional call only when condition holds
// - compare sets flags, writes no register
// - fetch loads register from scratchpad location
// - input drives port address, loads input data
// - port address set at end of fetch, held until next input
// - read strobe in second cycle, data sampled
// - interrupt ignored while enable flag clear
// - jump loads target, stack and flags kept
// - conditional jump only when condition holds
// - load copies immediate or register, flags kept
`timescale 1ns/1ps
`default_nettype none
module core_exec
	import core_pkg::*;
(
	input  wire logic                clk_sys_in,
	input  wire logic                rst_b_in,
	input  wire logic [INSTR_W-1:0]  instr_in,
	input  wire logic [DATA_W-1:0]   in_port_in,
	input  wire logic                interrupt_in,
	output logic      [ADDR_W-1:0]   pc_out,
	output logic      [DATA_W-1:0]   port_address_out,
	output logic                     read_strobe_out,
	output logic                     interrupt_ack_out,
	output logic                     zero_out,
	output logic                     carry_out,
	output logic                     irq_enable_out,
	output logic                     saved_zero_out,
	output logic                     saved_carry_out
);
	phase_t                 state, next_state;
	logic [INSTR_W-1:0]     instr_q, next_instr_q;
	logic [ADDR_W-1:0]      next_pc;
	logic [DATA_W-1:0]      next_port;
	logic                   next_rd, next_ack;
	logic                   next_zero, next_carry, next_ie;
	logic                   next_szero, next_scarry;
	logic [STACK_AW-1:0]    sp, next_sp;
	logic                   irq_meta, irq_sync;
	logic                   rf_we;
	logic [DATA_W-1:0]      rf_wdata;
	logic [DATA_W-1:0]      ra, rb;
	logic                   stk_we;
	logic [ADDR_W-1:0]      stk_wdata;
	logic [ADDR_W-1:0]      stack [0:STACK_DEPTH-1];
	logic [DATA_W-1:0]      scratch [0:(1<<SCR_AW)-1];

	opcode_t                op;
	logic [DATA_W-1:0]      imm, opnd;
	logic [ADDR_W-1:0]      target;
	logic [SCR_AW-1:0]      scr_addr;
	logic [DATA_W:0]        sum;
	logic                   cond_ok;
	logic                   take_irq;
	logic                   reg_form;
	logic [REG_AW-1:0]      rb_addr;

	assign op       = instr_q[OP_HI:OP_LO];
	assign imm      = instr_q[IMM_HI:0];
	assign target   = instr_q[ADDR_W-1:0];
	// register forms take the second register, the rest the immediate
	assign reg_form = (op == OP_ADD_R) || (op == OP_ADD_WITH_CARRY_ALT_OP_R)
	               || (op == OP_AND_R) || (op == OP_CMP_R)
	               || (op == OP_LOAD_R);
	assign opnd     = reg_form ? rb : imm;
	// port b follows the incoming word during fetch, so an input
	// instruction can latch its port address from a register
	assign rb_addr  = (state == S_ONE) ? instr_in[RY_HI:RY_LO]
	                                   : instr_q[RY_HI:RY_LO];
	assign scr_addr = (op == OP_FETCH_R) ? rb[SCR_AW-1:0]
	                                     : imm[SCR_AW-1:0];

	reg_bank reg_bank_inst (
		.clk_sys_in  (clk_sys_in),
		.we_in       (rf_we),
		.waddr_in    (instr_q[RX_HI:RX_LO]),
		.wdata_in    (rf_wdata),
		.raddr_a_in  (instr_q[RX_HI:RX_LO]),
		.raddr_b_in  (rb_addr),
		.rdata_a_out (ra),
		.rdata_b_out (rb)
	);

	// carry-in only joins the sum for the add-with-carry pair
	always_comb
	begin
		sum = {1'b0, ra} + {1'b0, opnd};
		if (op == OP_ADD_WITH_CARRY_ALT_OP_K || op == OP_ADD_WITH_CARRY_ALT_OP_R)
		begin
			sum = {1'b0, ra} + {1'b0, opnd}
			    + {{DATA_W{1'b0}}, carry_out};
		end
		unique case (cond_t'(instr_q[COND_HI:COND_LO]))
			COND_Z:  cond_ok = zero_out;
			COND_NZ: cond_ok = !zero_out;
			COND_C:  cond_ok = carry_out;
			COND_NC: cond_ok = !carry_out;
		endcase
	end

	always_comb
	begin
		next_state   = state;
		next_instr_q = instr_q;
		next_pc      = pc_out;
		next_port    = port_address_out;
		next_rd      = 1'b0;
		next_ack     = 1'b0;
		next_zero    = zero_out;
		next_carry   = carry_out;
		next_ie      = irq_enable_out;
		next_szero   = saved_zero_out;
		next_scarry  = saved_carry_out;
		next_sp      = sp;
		rf_we        = 1'b0;
		rf_wdata     = sum[DATA_W-1:0];
		stk_we       = 1'b0;
		stk_wdata    = pc_out;
		take_irq     = 1'b0;
		unique case (state)
			S_ONE:
			begin
				next_instr_q = instr_in;
				next_state   = S_TWO;
				if (instr_in[OP_HI:OP_LO] == OP_IN_R ||
				    instr_in[OP_HI:OP_LO] == OP_IN_K)
				begin
					// address set now stays through execute and beyond
					next_rd = 1'b1;
					next_port = (instr_in[OP_HI:OP_LO] == OP_IN_R)
					    ? rb
					    : instr_in[IMM_HI:0];
				end
			end
			S_TWO:
			begin
				next_pc    = pc_out + PC_STEP;
				next_state = S_ONE;
				unique case (op)
					OP_ADD_K, OP_ADD_R, OP_ADD_WITH_CARRY_ALT_OP_K, OP_ADD_WITH_CARRY_ALT_OP_R:
					begin
						rf_we      = 1'b1;
						next_zero  = (sum[DATA_W-1:0] == BYTE_ZERO);
						next_carry = sum[DATA_W];
					end
					OP_AND_K, OP_AND_R:
					begin
						rf_we      = 1'b1;
						rf_wdata   = ra & opnd;
						next_zero  = ((ra & opnd) == BYTE_ZERO);
						next_carry = 1'b0;
					end
					OP_CMP_K, OP_CMP_R:
					begin
						next_zero  = (ra == opnd);
						next_carry = (ra < opnd);
					end
					OP_CALL, OP_CALL_C:
					begin
						if (op == OP_CALL || cond_ok)
						begin
							stk_we  = 1'b1;
							next_sp = sp + SP_STEP;
							next_pc = target;
						end
					end
					OP_JUMP, OP_JUMP_C:
					begin
						if (op == OP_JUMP || cond_ok)
						begin
							next_pc = target;
						end
					end
					OP_IRQ_EN:  next_ie = 1'b1;
					OP_IRQ_DIS: next_ie = 1'b0;
					OP_FETCH_R, OP_FETCH_K:
					begin
						rf_we    = 1'b1;
						rf_wdata = scratch[scr_addr];
					end
					OP_IN_R, OP_IN_K:
					begin
						rf_we    = 1'b1;
						rf_wdata = in_port_in;
					end
					OP_LOAD_K, OP_LOAD_R:
					begin
						rf_we    = 1'b1;
						rf_wdata = opnd;
					end
					default:
					begin
						rf_we = 1'b0;
					end
				endcase
				// a two-cycle request always spans one instruction end
				take_irq = next_ie && irq_sync;
				if (take_irq)
				begin
					next_state = S_IRQ1;
				end
			end
			S_IRQ1:
			begin
				next_szero  = zero_out;
				next_scarry = carry_out;
				next_ie     = 1'b0;
				stk_we      = 1'b1;
				next_sp     = sp + SP_STEP;
				next_pc     = IRQ_VEC;
				next_ack    = 1'b1;
				next_state  = S_IRQ2;
			end
			S_IRQ2:
			begin
				next_state = S_ONE;
			end
		endcase
		// stack wraps instead of overflowing, as the core cannot trap
		if (next_sp == STACK_AW'(STACK_DEPTH))
		begin
			next_sp = SP_RESET;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		irq_meta <= interrupt_in;
		irq_sync <= irq_meta;
		if (stk_we)
		begin
			stack[sp] <= stk_wdata;
		end
		if (!rst_b_in)
		begin
			state             <= S_ONE;
			instr_q           <= '0;
			pc_out            <= PC_RESET;
			port_address_out  <= BYTE_ZERO;
			read_strobe_out   <= 1'b0;
			interrupt_ack_out <= 1'b0;
			zero_out          <= 1'b0;
			carry_out         <= 1'b0;
			irq_enable_out    <= 1'b0;
			saved_zero_out    <= 1'b0;
			saved_carry_out   <= 1'b0;
			sp                <= SP_RESET;
		end
		else
		begin
			state             <= next_state;
			instr_q           <= next_instr_q;
			pc_out            <= next_pc;
			port_address_out  <= next_port;
			read_strobe_out   <= next_rd;
			interrupt_ack_out <= next_ack;
			zero_out          <= next_zero;
			carry_out         <= next_carry;
			irq_enable_out    <= next_ie;
			saved_zero_out    <= next_szero;
			saved_carry_out   <= next_scarry;
			sp                <= next_sp;
		end
	end

	// scratchpad is only cleared to zero at start; nothing in this project writes it
	initial
	begin
		for (int i = 0; i < (1<<SCR_AW); i++)
		begin
			scratch[i] = BYTE_ZERO;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	add_result_a: assert property (
		(state == S_TWO && op == OP_ADD_K)
		|-> (rf_we && rf_wdata == ra + imm))
		else $error("add result wrong");
	add_zero_a: assert property (
		(state == S_TWO && (op == OP_ADD_R || op == OP_ADD_WITH_CARRY_ALT_OP_R))
		|=> (zero_out == ($past(rf_wdata) == BYTE_ZERO)))
		else $error("zero flag wrong after add");
	and_carry_a: assert property (
		(state == S_TWO && (op == OP_AND_K || op == OP_AND_R))
		|=> !carry_out)
		else $error("and left carry set");
	cmp_flags_a: assert property (
		(state == S_TWO && (op == OP_CMP_K || op == OP_CMP_R))
		|-> !rf_we ##1 (carry_out == $past(ra < opnd)
		&& zero_out == $past(ra == opnd)))
		else $error("compare flags or write wrong");
	ie_set_a: assert property (
		(state == S_TWO && op == OP_IRQ_EN) |=> irq_enable_out)
		else $error("enable did not set flag");
	irq_vector_a: assert property (
		(state == S_IRQ1) |=> (pc_out == IRQ_VEC && !irq_enable_out
		&& interrupt_ack_out && sp != $past(sp)
		&& stack[$past(sp)] == $past(pc_out)))
		else $error("interrupt entry wrong");
	irq_ignored_a: assert property (
		(state == S_TWO && !next_ie) |=> (state != S_IRQ1))
		else $error("interrupt taken while disabled");
	strobe_phase_a: assert property (
		read_strobe_out |-> (state == S_TWO
		&& (op == OP_IN_R || op == OP_IN_K)))
		else $error("read strobe out of phase");
	port_hold_a: assert property (
		read_strobe_out |=> $stable(port_address_out))
		else $error("port address not held");
	jump_target_a: assert property (
		(state == S_TWO && op == OP_JUMP)
		|=> (pc_out == $past(target) && $stable(sp)))
		else $error("jump target wrong");
	call_push_a: assert property (
		(state == S_TWO && op == OP_CALL) |=> (pc_out == $past(target)
		&& $stable(zero_out) && $stable(carry_out)
		&& stack[$past(sp)] == $past(pc_out)))
		else $error("call wrong");

	irq_taken_c: cover property (state == S_IRQ1);
	input_done_c: cover property (read_strobe_out);
	cond_call_c: cover property (state == S_TWO && op == OP_CALL_C
		&& cond_ok);
endmodule : core_exec
`default_nettype wire

// [core_pkg.sv]
// Purpose: shared constants for the 8-bit instruction core
// Assumes: 18-bit instruction word, 10-bit program address
// Notes:   opcode layout is internal to this core
package core_pkg;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 10;
	localparam int INSTR_W  = 18;
	localparam int REG_AW   = 4;
	localparam int SCR_AW   = 6;
	localparam int STACK_AW = 5;
	// field positions inside an instruction word
	localparam int OP_HI    = 17;
	localparam int OP_LO    = 12;
	localparam int RX_HI    = 11;
	localparam int RX_LO    = 8;
	localparam int RY_HI    = 7;
	localparam int RY_LO    = 4;
	localparam int IMM_HI   = 7;
	localparam int COND_HI  = 11;
	localparam int COND_LO  = 10;
	typedef logic [OP_HI-OP_LO:0] opcode_t;
	localparam opcode_t OP_ADD_K   = 6'h00;
	localparam opcode_t OP_ADD_R   = 6'h01;
	localparam opcode_t OP_ADD_WITH_CARRY_ALT_OP_K  = 6'h02;
	localparam opcode_t OP_ADD_WITH_CARRY_ALT_OP_R  = 6'h03;
	localparam opcode_t OP_AND_K   = 6'h04;
	localparam opcode_t OP_AND_R   = 6'h05;
	localparam opcode_t OP_CALL    = 6'h06;
	localparam opcode_t OP_CMP_K   = 6'h07;
	localparam opcode_t OP_CMP_R   = 6'h08;
	localparam opcode_t OP_IRQ_DIS = 6'h09;
	localparam opcode_t OP_IRQ_EN  = 6'h0a;
	localparam opcode_t OP_FETCH_R = 6'h0b;
	localparam opcode_t OP_FETCH_K = 6'h0c;
	localparam opcode_t OP_IN_R    = 6'h0d;
	localparam opcode_t OP_IN_K    = 6'h0e;
	localparam opcode_t OP_JUMP    = 6'h0f;
	localparam opcode_t OP_LOAD_K  = 6'h10;
	localparam opcode_t OP_LOAD_R  = 6'h11;
	localparam opcode_t OP_CALL_C  = 6'h12;
	localparam opcode_t OP_JUMP_C  = 6'h13;
	typedef logic [1:0] cond_t;
	localparam cond_t COND_Z  = 2'h0;
	localparam cond_t COND_NZ = 2'h1;
	localparam cond_t COND_C  = 2'h2;
	localparam cond_t COND_NC = 2'h3;
	localparam logic [ADDR_W-1:0]   PC_RESET  = 10'h000;
	localparam logic [ADDR_W-1:0]   IRQ_VEC   = 10'h3ff;
	localparam logic [DATA_W-1:0]   BYTE_ZERO = 8'h00;
	localparam logic [STACK_AW-1:0] SP_RESET  = 5'h00;
	localparam logic [STACK_AW-1:0] SP_STEP   = 5'h01;
	localparam logic [ADDR_W-1:0]   PC_STEP   = 10'h001;
	localparam int STACK_DEPTH = 31;
	typedef enum logic [3:0] {
		S_ONE  = 4'h1,
		S_TWO  = 4'h2,
		S_IRQ1 = 4'h4,
		S_IRQ2 = 4'h8
	} phase_t;
endpackage : core_pkg

// [mcu_instruction_execute_a_to_l_test.sv]
// Purpose: self-checking bench for the instruction core
// Assumes: program memory modelled as an array read by pc_out
// Notes:   registers are observed through port address of input ops
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_a_to_l_test
	import core_pkg::*;
;
	localparam logic [INSTR_W-1:0] NOP = 18'h3f000;
	logic                clk_sys_in = 1'b0;
	logic                rst_b_in;
	logic [INSTR_W-1:0]  instr_in;
	logic [DATA_W-1:0]   in_port_in;
	logic                interrupt_in;
	logic [ADDR_W-1:0]   pc_out;
	logic [DATA_W-1:0]   port_address_out;
	logic                read_strobe_out;
	logic                interrupt_ack_out;
	logic                zero_out;
	logic                carry_out;
	logic                irq_enable_out;
	logic                saved_zero_out;
	logic                saved_carry_out;
	logic [INSTR_W-1:0]  rom [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0]   nxt;
	logic [3:0]          taken = 4'h9;
	int                  err_count = 0;
	int                  comparisons = 0;
	int                  acks = 0;
	int                  n;
	always #10 clk_sys_in = ~clk_sys_in;
	assign instr_in = rom[pc_out];
	always @(posedge clk_sys_in)
		if (interrupt_ack_out === 1'b1)
			acks <= acks + 1;
	core_exec core_exec_inst (
		.clk_sys_in        (clk_sys_in),
		.rst_b_in          (rst_b_in),
		.instr_in          (instr_in),
		.in_port_in        (in_port_in),
		.interrupt_in      (interrupt_in),
		.pc_out            (pc_out),
		.port_address_out  (port_address_out),
		.read_strobe_out   (read_strobe_out),
		.interrupt_ack_out (interrupt_ack_out),
		.zero_out          (zero_out),
		.carry_out         (carry_out),
		.irq_enable_out    (irq_enable_out),
		.saved_zero_out    (saved_zero_out),
		.saved_carry_out   (saved_carry_out)
	);
	port_peripheral port_peripheral_inst (
		.read_strobe_in  (read_strobe_out),
		.port_address_in (port_address_out),
		.data_out        (in_port_in)
	);
	function automatic logic [INSTR_W-1:0] ik(opcode_t op, logic [3:0] rx,
		logic [7:0] k);
		return {op, rx, k};
	endfunction : ik
	function automatic logic [INSTR_W-1:0] ib(opcode_t op, cond_t c,
		logic [ADDR_W-1:0] a);
		return {op, c, a};
	endfunction : ib
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk(logic [9:0] seen, logic [9:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic fl(logic z, logic c);
		chk(zero_out, z);
		chk(carry_out, c);
	endtask : fl
	// one instruction is always two cycles
	task automatic exec(logic [INSTR_W-1:0] ins);
		rom[pc_out] = ins;
		@(posedge clk_sys_in);
		@(posedge clk_sys_in);
		#1;
	endtask : exec
	// r15 is sacrificed as the target of every read-back
	task automatic rd(logic [3:0] r, logic [7:0] exp);
		rom[pc_out] = ik(OP_IN_R, 4'hf, {r, 4'h0});
		@(posedge clk_sys_in);
		#1;
		chk(read_strobe_out, 1'b1);
		chk(port_address_out, exp);
		@(posedge clk_sys_in);
		#1;
		chk(read_strobe_out, 1'b0);
		chk(port_address_out, exp);
	endtask : rd
	task automatic done(string name);
		$display("test %s finished", name);
	endtask : done
	initial
	begin
		#100000;
		err_count++;
		$display("FAIL t=%0t watchdog expired", $time);
		report_and_stop();
	end
	initial
	begin
		rst_b_in = 1'b0;
		interrupt_in = 1'b0;
		for (int i = 0; i < (1 << ADDR_W); i++)
			rom[i] = NOP;
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk(pc_out, PC_RESET);
		fl(1'b0, 1'b0);
		chk(irq_enable_out, 1'b0);
		rst_b_in = 1'b1;
		exec(ik(OP_LOAD_K, 4'h1, 8'hff));
		exec(ik(OP_LOAD_K, 4'h2, 8'h01));
		fl(1'b0, 1'b0);
		exec(ik(OP_ADD_R, 4'h1, 8'h20));
		fl(1'b1, 1'b1);
		rd(4'h1, 8'h00);
		exec(ik(OP_ADD_WITH_CARRY_ALT_OP_K, 4'h1, 8'h7f));
		fl(1'b0, 1'b0);
		rd(4'h1, 8'h80);
		exec(ik(OP_ADD_WITH_CARRY_ALT_OP_R, 4'h1, 8'h10));
		fl(1'b1, 1'b1);
		exec(ik(OP_AND_K, 4'h2, 8'h03));
		fl(1'b0, 1'b0);
		rd(4'h2, 8'h01);
		exec(ik(OP_AND_R, 4'h2, 8'h10));
		fl(1'b1, 1'b0);
		exec(ik(OP_CMP_K, 4'h2, 8'h01));
		fl(1'b0, 1'b1);
		rd(4'h2, 8'h00);
		exec(ik(OP_CMP_R, 4'h1, 8'h20));
		fl(1'b1, 1'b0);
		exec(ik(OP_LOAD_K, 4'h3, 8'hff));
		exec(ik(OP_LOAD_R, 4'h4, 8'h30));
		rd(4'h4, 8'hff);
		fl(1'b1, 1'b0);
		exec(ik(OP_FETCH_K, 4'h4, 8'h3f));
		fl(1'b1, 1'b0);
		rd(4'h4, 8'h00);
		exec(ik(OP_FETCH_R, 4'h3, 8'h20));
		rd(4'h3, 8'h00);
		exec(ik(OP_IN_K, 4'h6, 8'ha5));
		chk(port_address_out, 8'ha5);
		rd(4'h6, 8'hff);
		done("data");
		// zero set, carry clear: only Z and NC conditions branch
		for (int i = 0; i < 4; i++)
		begin
			nxt = taken[i] ? 10'h100 + 10'(i) : pc_out + PC_STEP;
			exec(ib(OP_JUMP_C, cond_t'(i), 10'h100 + 10'(i)));
			chk(pc_out, nxt);
			nxt = taken[i] ? 10'h200 + 10'(i) : pc_out + PC_STEP;
			exec(ib(OP_CALL_C, cond_t'(i), 10'h200 + 10'(i)));
			chk(pc_out, nxt);
			fl(1'b1, 1'b0);
		end
		exec(ib(OP_CALL, 2'h0, 10'h050));
		chk(pc_out, 10'h050);
		fl(1'b1, 1'b0);
		exec(ib(OP_JUMP, 2'h0, 10'h3a0));
		chk(pc_out, 10'h3a0);
		fl(1'b1, 1'b0);
		done("branch");
		exec(ik(OP_IRQ_EN, 4'h0, 8'h00));
		chk(irq_enable_out, 1'b1);
		fl(1'b1, 1'b0);
		exec(ik(OP_IRQ_DIS, 4'h0, 8'h00));
		chk(irq_enable_out, 1'b0);
		interrupt_in = 1'b1;
		n = acks;
		repeat (4) exec(NOP);
		chk(10'(acks), 10'(n));
		interrupt_in = 1'b0;
		repeat (3) exec(NOP);
		exec(ik(OP_IRQ_EN, 4'h0, 8'h00));
		interrupt_in = 1'b1;
		n = 0;
		while (interrupt_ack_out !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		chk(interrupt_ack_out, 1'b1);
		chk(pc_out, IRQ_VEC);
		chk(irq_enable_out, 1'b0);
		chk(saved_zero_out, 1'b1);
		chk(saved_carry_out, 1'b0);
		interrupt_in = 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk(interrupt_ack_out, 1'b0);
		exec(ik(OP_LOAD_K, 4'h5, 8'h3c));
		rd(4'h5, 8'h3c);
		done("interrupt");
		report_and_stop();
	end
endmodule : mcu_instruction_execute_a_to_l_test
`default_nettype wire

// [port_peripheral.sv]
// Purpose: port-bus peripheral answering input cycles of the core
// Assumes: data need only be right while the read strobe is high
// Notes:   shows the inverse outside the strobe to expose early sampling
`timescale 1ns/1ps
`default_nettype none
module port_peripheral
	import core_pkg::*;
(
	input  wire logic              read_strobe_in,
	input  wire logic [DATA_W-1:0] port_address_in,
	output logic      [DATA_W-1:0] data_out
);
	localparam logic [DATA_W-1:0] SALT = 8'h5a;
	// valid only in the strobe cycle
	assign data_out = read_strobe_in ? (port_address_in ^ SALT)
		: ~(port_address_in ^ SALT);
endmodule : port_peripheral
`default_nettype wire

// [reg_bank.sv]
// Purpose: sixteen general registers, two read ports, one write port
// Assumes: write on rising edge when write enable high
// Notes:   reads are combinational so execute sees fresh operands
`timescale 1ns/1ps
`default_nettype none
module reg_bank
	import core_pkg::*;
(
	input  wire logic                clk_sys_in,
	input  wire logic                we_in,
	input  wire logic [REG_AW-1:0]   waddr_in,
	input  wire logic [DATA_W-1:0]   wdata_in,
	input  wire logic [REG_AW-1:0]   raddr_a_in,
	input  wire logic [REG_AW-1:0]   raddr_b_in,
	output logic      [DATA_W-1:0]   rdata_a_out,
	output logic      [DATA_W-1:0]   rdata_b_out
);
	logic [DATA_W-1:0] regs [0:(1<<REG_AW)-1];

	always_ff @(posedge clk_sys_in)
	begin
		if (we_in)
		begin
			regs[waddr_in] <= wdata_in;
		end
	end

	assign rdata_a_out = regs[raddr_a_in];
	assign rdata_b_out = regs[raddr_b_in];
endmodule : reg_bank
`default_nettype wire
